// ### src/pgr_pkg.sv
package pgr_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_PIN_A_ROUTE = 8'h30;
  localparam logic [7:0] ADDR_PIN_B_ROUTE = 8'h31;
  localparam logic [7:0] ADDR_EVENT_ENABLE_ONE = 8'h32;
  localparam logic [7:0] ADDR_EVENT_FLAG_ONE = 8'h34;

  // ****************************************************************
  // route register fields
  // ****************************************************************
  localparam int BIT_INVERT = 7;
  localparam int BIT_CHARGE_DONE = 4;
  localparam int BIT_INPUT_OK = 3;
  localparam int BIT_BATTERY_OK = 2;
  localparam int BIT_BOOST_GOOD = 1;
  localparam int BIT_STEP_DOWN_GOOD = 0;
  localparam logic [7:0] ROUTE_WRITE_MASK = 8'h9F;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] ROUTE_B_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************************************
  // event enable fields
  // ****************************************************************
  localparam int BIT_LOW_CHARGE_IRQ = 7;
  localparam int BIT_CHARGE_ACCUM_IRQ = 6;
  localparam int BIT_ADAPTIVE_LIMIT_IRQ = 5;
  localparam int BIT_PROTECTION_IRQ = 4;
  localparam int BIT_THERMISTOR_IRQ = 3;
  localparam int BIT_CELL_VOLTAGE_IRQ = 2;
  localparam int BIT_CHARGER_STATE_IRQ = 1;
  localparam int BIT_INPUT_THRESHOLD_IRQ = 0;

endpackage : pgr_pkg

// ### src/pgr_pin_route.sv
module pgr_pin_route (
  input wire logic [7:0] route_i, // route register
  input wire logic [4:0] status_i, // {done, input, batt, boost, buck}
  input wire logic buck_load_switch_i, // buck in load switch mode
  output logic pin_o // pin level
);

  logic [4:0] sel;
  logic any_true;

  assign sel[4] = route_i[pgr_pkg::BIT_CHARGE_DONE];
  assign sel[3] = route_i[pgr_pkg::BIT_INPUT_OK];
  assign sel[2] = route_i[pgr_pkg::BIT_BATTERY_OK];
  assign sel[1] = route_i[pgr_pkg::BIT_BOOST_GOOD];
  assign sel[0] = route_i[pgr_pkg::BIT_STEP_DOWN_GOOD] & ~buck_load_switch_i;
  assign any_true = |(sel & status_i);
  assign pin_o = any_true ^ route_i[pgr_pkg::BIT_INVERT];

endmodule : pgr_pin_route

// ### src/pgr_power_good_routing.sv
// What this block does
// - route A bit 7 set makes pin A active low.
// - route B bit 7 set makes pin B active low; resets to 0.
// - bit 4 routes charge complete to the pin; resets to 0.
// - bit 3 routes input supply okay to the pin.
// - bit 2 routes battery okay to the pin; resets to 0.
// - bit 1 routes buck-boost power good to the pin; resets to 0.
// - bit 0 routes buck power good to the pin.
// - buck route ignored while buck is a load switch.
// - enable bits 7,6 allow low-charge and accumulation events; reset 0.
// - enable bits 5,4 allow adaptive limit and protection events; reset 0.
// - enable bits 3,2 allow thermistor and cell voltage events; reset 0.
// - enable bits 1,0 allow charger state and input threshold events; reset 0.
// - event flags clear when their register is read.
// - input okay only between okay and overvoltage thresholds.
module pgr_power_good_routing #(
  parameter logic [7:0] ROUTE_A_RESET = 8'h00 // factory-set default
) (
  input wire logic clk_sys_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  input wire logic [7:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // write data
  output logic [7:0] reg_rdata_o, // read data
  input wire logic charge_done_i, // charge complete status
  input wire logic input_above_ok_i, // input above okay threshold
  input wire logic input_below_ov_i, // input below overvoltage threshold
  input wire logic battery_ok_i, // battery okay status
  input wire logic boost_good_i, // buck-boost power good
  input wire logic step_down_good_i, // buck power good
  input wire logic buck_load_switch_i, // buck configured as load switch
  input wire logic [7:0] event_i, // event pulses, enable bit order
  output logic status_pin_a_o, // power-good pin a
  output logic status_pin_b_o, // power-good pin b
  output logic input_ok_o, // input supply okay status
  output logic irq_o // interrupt request, active high
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] power_good_a_route;
  logic [7:0] power_good_b_route;
  logic [7:0] event_enable_one;
  logic [7:0] event_flag_one;
  logic [7:0] next_flag;
  logic [4:0] status_vec;
  logic wr_a, wr_b, wr_en, rd_flag;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit

  assign wr_a = reg_wr_i & hit(reg_addr_i, pgr_pkg::ADDR_PIN_A_ROUTE);
  assign wr_b = reg_wr_i & hit(reg_addr_i, pgr_pkg::ADDR_PIN_B_ROUTE);
  assign wr_en = reg_wr_i & hit(reg_addr_i, pgr_pkg::ADDR_EVENT_ENABLE_ONE);
  assign rd_flag = reg_rd_i & hit(reg_addr_i, pgr_pkg::ADDR_EVENT_FLAG_ONE);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if ((ROUTE_A_RESET & ~pgr_pkg::ROUTE_WRITE_MASK) != 8'h00 ||
      ROUTE_A_RESET[pgr_pkg::BIT_CHARGE_DONE] || ROUTE_A_RESET[pgr_pkg::BIT_BATTERY_OK] ||
      ROUTE_A_RESET[pgr_pkg::BIT_BOOST_GOOD]) begin : g_bad_route_a_reset
    $error("route a reset value sets a bit that must reset to zero");
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_good_a_route <= ROUTE_A_RESET;
      power_good_b_route <= pgr_pkg::ROUTE_B_RESET;
      event_enable_one <= pgr_pkg::ENABLE_RESET;
    end else begin
      if (wr_a) begin
        power_good_a_route <= reg_wdata_i & pgr_pkg::ROUTE_WRITE_MASK;
      end
      if (wr_b) begin
        power_good_b_route <= reg_wdata_i & pgr_pkg::ROUTE_WRITE_MASK;
      end
      if (wr_en) begin
        event_enable_one <= reg_wdata_i;
      end
    end
  end

  property p_write_a;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      wr_a |=> power_good_a_route == ($past(reg_wdata_i) & pgr_pkg::ROUTE_WRITE_MASK);
  endproperty
  a_write_a: assert property (p_write_a) else $error("route a not written");

  property p_write_b;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      wr_b |=> power_good_b_route == ($past(reg_wdata_i) & pgr_pkg::ROUTE_WRITE_MASK);
  endproperty
  a_write_b: assert property (p_write_b) else $error("route b not written");

  // ****************************************************************
  // event flags, set wins over read clear
  // ****************************************************************
  assign next_flag = (rd_flag ? pgr_pkg::FLAG_RESET : event_flag_one) | event_i;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_flag_one <= pgr_pkg::FLAG_RESET;
      irq_o <= 1'b0;
    end else begin
      event_flag_one <= next_flag;
      irq_o <= |(next_flag & event_enable_one);
    end
  end

  property p_irq_off;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      ((next_flag & event_enable_one) == 8'h00) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enabled flag");

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= pgr_pkg::READ_ZERO;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        pgr_pkg::ADDR_PIN_A_ROUTE: reg_rdata_o <= power_good_a_route;
        pgr_pkg::ADDR_PIN_B_ROUTE: reg_rdata_o <= power_good_b_route;
        pgr_pkg::ADDR_EVENT_ENABLE_ONE: reg_rdata_o <= event_enable_one;
        pgr_pkg::ADDR_EVENT_FLAG_ONE: reg_rdata_o <= event_flag_one;
        default: reg_rdata_o <= pgr_pkg::READ_ZERO;
      endcase
    end
  end

  property p_read_flags;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      rd_flag |=> reg_rdata_o == $past(event_flag_one);
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flags not returned");

  // ****************************************************************
  // pin routing
  // ****************************************************************
  assign input_ok_o = input_above_ok_i & input_below_ov_i;
  assign status_vec = {charge_done_i, input_ok_o, battery_ok_i, boost_good_i, step_down_good_i};

  pgr_pin_route u_route_a (
    .route_i(power_good_a_route),
    .status_i(status_vec),
    .buck_load_switch_i(buck_load_switch_i),
    .pin_o(status_pin_a_o)
  );

  pgr_pin_route u_route_b (
    .route_i(power_good_b_route),
    .status_i(status_vec),
    .buck_load_switch_i(buck_load_switch_i),
    .pin_o(status_pin_b_o)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_pin_a_any;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      status_pin_a_o == ((|(power_good_a_route[4:1] & status_vec[4:1]) |
        (power_good_a_route[0] & ~buck_load_switch_i & step_down_good_i)) ^
        power_good_a_route[7]);
  endproperty
  a_pin_a_any: assert property (p_pin_a_any) else $error("pin a mismatch");

  property p_pin_b_any;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      status_pin_b_o == ((|(power_good_b_route[4:1] & status_vec[4:1]) |
        (power_good_b_route[0] & ~buck_load_switch_i & step_down_good_i)) ^
        power_good_b_route[7]);
  endproperty
  a_pin_b_any: assert property (p_pin_b_any) else $error("pin b mismatch");

  property p_load_switch_b;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (buck_load_switch_i && power_good_b_route[4:1] == 4'h0) |->
        status_pin_b_o == power_good_b_route[7];
  endproperty
  a_load_switch_b: assert property (p_load_switch_b) else $error("buck leaks to pin b");

  property p_inv_b;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (power_good_b_route[7] && power_good_b_route[3] && input_ok_o) |-> !status_pin_b_o;
  endproperty
  a_inv_b: assert property (p_inv_b) else $error("pin b polarity wrong");

  property p_input_ok;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      !input_below_ov_i |-> !input_ok_o;
  endproperty
  a_input_ok: assert property (p_input_ok) else $error("input ok above ov");

  property p_read_clear;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (rd_flag && event_i == 8'h00) |=> event_flag_one == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared");

  property p_set_wins;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      event_i[0] |=> event_flag_one[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_masked;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      ($past(event_enable_one) == 8'h00) |-> !irq_o;
  endproperty
  a_masked: assert property (p_masked) else $error("masked irq raised");

  property p_irq_on;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (event_i[7] && event_enable_one[7]) |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled irq missing");

  property p_write_en;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      wr_en |=> event_enable_one == $past(reg_wdata_i);
  endproperty
  a_write_en: assert property (p_write_en) else $error("enable not written");

endmodule : pgr_power_good_routing

// ### verif/pgr_host_model.sv
module pgr_host_model (
  input wire logic clk_i, // system clock
  input wire logic [7:0] rdata_i, // read data
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  output logic [7:0] addr_o, // address
  output logic [7:0] wdata_o // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    {wr_o, addr_o, wdata_o} <= {1'b1, a, v};
    @(posedge clk_i);
    // idle bus shows a changed pattern, not the old one
    {wr_o, addr_o, wdata_o} <= {1'b0, ~a, ~v};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    {rd_o, addr_o} <= {1'b1, a};
    @(posedge clk_i);
    {rd_o, addr_o} <= {1'b0, ~a};
    @(posedge clk_i);
    v = rdata_i;
  endtask : rd
endmodule : pgr_host_model

// ### verif/power_good_routing_and_irq_enable_bench.sv
module power_good_routing_and_irq_enable_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, resetn_i, reg_wr_i, reg_rd_i, irq_o, pa, pb, iok;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, event_i, ra, rb, d, m;
  logic cd, ao, bo, bt, bg, sg, ls;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [7:0] adr[5] = '{pgr_pkg::ADDR_PIN_A_ROUTE, pgr_pkg::ADDR_PIN_B_ROUTE,
    pgr_pkg::ADDR_EVENT_ENABLE_ONE, pgr_pkg::ADDR_EVENT_FLAG_ONE, 8'h40};
  pgr_power_good_routing i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .charge_done_i(cd),
    .input_above_ok_i(ao), .input_below_ov_i(bo), .battery_ok_i(bt), .boost_good_i(bg),
    .step_down_good_i(sg), .buck_load_switch_i(ls), .event_i(event_i),
    .status_pin_a_o(pa), .status_pin_b_o(pb), .input_ok_o(iok), .irq_o(irq_o));
  pgr_host_model i_host (.clk_i(clk_sys_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  // ****************************************************************
  // expectation and reporting
  // ****************************************************************
  function automatic logic exp_pin(input logic [7:0] r);
    return (|(r[4:0] & {cd, ao & bo, bt, bg, sg & ~ls})) ^ r[7];
  endfunction : exp_pin
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_sys_i);
    event_i <= v;
    @(posedge clk_sys_i);
    event_i <= 8'h00;
    @(negedge clk_sys_i);
  endtask : pulse
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {resetn_i, cd, ao, bo, bt, bg, sg, ls, event_i} = 16'h0000;
    void'($urandom(32'hCCD3));
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    foreach (adr[k]) begin
      i_host.rd(adr[k], d);
      chk(d, 8'h00);
    end
    $display("test reset done");
    for (int i = 0; i < 120; i++) begin
      ra = (i == 0) ? 8'h81 : 8'($urandom);
      rb = (i == 0) ? 8'h08 : 8'($urandom);
      i_host.wr(pgr_pkg::ADDR_PIN_A_ROUTE, ra);
      i_host.wr(pgr_pkg::ADDR_PIN_B_ROUTE, rb);
      i_host.rd(pgr_pkg::ADDR_PIN_A_ROUTE, d);
      chk(d, ra & pgr_pkg::ROUTE_WRITE_MASK);
      i_host.rd(pgr_pkg::ADDR_PIN_B_ROUTE, d);
      chk(d, rb & pgr_pkg::ROUTE_WRITE_MASK);
      @(posedge clk_sys_i);
      {cd, ao, bo, bt, bg, sg, ls} <= (i == 0) ? 7'h03 : 7'($urandom);
      @(negedge clk_sys_i);
      chk({7'h00, pa}, {7'h00, exp_pin(ra)});
      chk({7'h00, pb}, {7'h00, exp_pin(rb)});
      chk({7'h00, iok}, {7'h00, ao & bo});
    end
    $display("test routing done");
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      i_host.wr(pgr_pkg::ADDR_EVENT_ENABLE_ONE, m);
      i_host.rd(pgr_pkg::ADDR_EVENT_ENABLE_ONE, d);
      chk(d, m);
      pulse(~m);
      chk({7'h00, irq_o}, 8'h00);
      i_host.rd(pgr_pkg::ADDR_EVENT_FLAG_ONE, d);
      chk(d, ~m);
      i_host.rd(pgr_pkg::ADDR_EVENT_FLAG_ONE, d);
      chk(d, 8'h00);
      pulse(m);
      chk({7'h00, irq_o}, 8'h01);
      i_host.rd(pgr_pkg::ADDR_EVENT_FLAG_ONE, d);
      chk(d, m);
      chk({7'h00, irq_o}, 8'h00);
    end
    $display("test events done");
    report_and_stop();
  end
endmodule : power_good_routing_and_irq_enable_bench
